// >>> verilog/pid_sleep_defines.vh
`ifndef PID_SLEEP_DEFINES_VH
`define PID_SLEEP_DEFINES_VH

// Clock and time base
`define CLK_PERIOD_NS 5
`define SEC_NS 1000000000
`define CS_NS 10000000

// Source select codes: 0 none, 1..16 digital input, 17..32 control bit
`define SRC_NONE 6'h00
`define SRC_DI_LAST 6'h10
`define SRC_CW_FIRST 6'h11
`define SRC_CW_LAST 6'h20

// Sleep detection modes
`define SLP_NONE 3'h0
`define SLP_SWITCH 3'h1
`define SLP_SPEED 3'h2
`define SLP_POWER 3'h3
`define SLP_MULTI 3'h4

// Wake-up modes, feedback is the reset choice
`define WAKE_FEEDBACK 1'b0
`define WAKE_ERROR 1'b1

// Reset value of the speed command and the start ramp level
`define SPEED_RST 16'h0000

// Supervisor states
`define ST_STOP 3'h0
`define ST_MAN 3'h1
`define ST_START 3'h2
`define ST_PID 3'h3
`define ST_BOOST 3'h4
`define ST_SLEEP 3'h5

`endif

// >>> verilog/start_ramp.v
`timescale 1ns/1ps
`include "pid_sleep_defines.vh"

module start_ramp (
   input wire sys_clk,
   input wire rst_n,
   input wire clear,
   input wire tick,
   input wire [15:0] full_scale,
   input wire [13:0] time_cs,
   input wire [15:0] target,
   output reg [15:0] level_reg,
   output wire done
);

   reg [31:0] acc_reg;
   wire [31:0] time_ext;

   // Zero time treated as the shortest ramp
   assign time_ext = (time_cs == 14'h0000) ? 32'h00000001 : {18'h00000, time_cs};
   assign done = (level_reg >= target);

   // Full scale per accel time: credit each tick, spend one step per clock
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= 32'h00000000;
         level_reg <= `SPEED_RST;
      end else if (clear) begin
         acc_reg <= 32'h00000000;
         level_reg <= `SPEED_RST;
      end else if (tick) begin
         acc_reg <= acc_reg + {16'h0000, full_scale};
      end else if (acc_reg >= time_ext && !done) begin
         acc_reg <= acc_reg - time_ext;
         level_reg <= level_reg + 16'h0001;
      end
   end

endmodule // start_ramp

// >>> verilog/pid_sleep_wake_supervisor.v
`timescale 1ns/1ps
`include "pid_sleep_defines.vh"

module pid_sleep_wake_supervisor #(
   parameter SEC_CYCLES = `SEC_NS / `CLK_PERIOD_NS,
   parameter CS_CYCLES = `CS_NS / `CLK_PERIOD_NS
) (
   input wire sys_clk,
   input wire nrst,
   input wire [15:0] di_pins,
   input wire [15:0] ctrl_word,
   input wire run_cmd,
   input wire pid_configured,
   input wire chan1_sel,
   input wire pid_auto,
   input wire pid_inversion,
   input wire signed [15:0] pid_out,
   input wire signed [15:0] pid_error,
   input wire [15:0] pid_error_warning_level,
   input wire [5:0] int_off_sel,
   input wire signed [15:0] min_out,
   input wire signed [15:0] max_out,
   input wire [13:0] accel_time_cs,
   input wire start_accel_en,
   input wire [13:0] start_accel_cs,
   input wire [15:0] low_speed,
   input wire [15:0] start_ref_freq,
   input wire [15:0] manual_freq,
   input wire [2:0] sleep_mode,
   input wire [5:0] sleep_sw_sel,
   input wire [15:0] sleep_speed,
   input wire [15:0] sleep_on_power,
   input wire [15:0] out_freq,
   input wire [15:0] out_power,
   input wire [11:0] sleep_delay_s,
   input wire [15:0] boost_speed,
   input wire [11:0] boost_time_s,
   input wire wake_mode,
   input wire [15:0] wake_level,
   input wire [15:0] wake_err,
   input wire [15:0] pid_ref,
   input wire [15:0] feedback,
   output reg signed [15:0] speed_cmd_reg,
   output reg motor_run_reg,
   output reg pid_run_reg,
   output reg int_hold_reg,
   output reg err_warn_reg,
   output reg sleep_reg,
   output reg boost_reg,
   output reg pid_mode_reg
);

   // Pick a source bit from the digital inputs or the control word
   function src_pick;
      input [5:0] sel;
      input [15:0] di;
      input [15:0] cw;
      reg [5:0] idx;
      begin
         idx = 6'h00;
         src_pick = 1'b0;
         if (sel != `SRC_NONE && sel <= `SRC_DI_LAST) begin
            idx = sel - 6'h01;
            src_pick = di[idx[3:0]];
         end else if (sel >= `SRC_CW_FIRST && sel <= `SRC_CW_LAST) begin
            idx = sel - `SRC_CW_FIRST;
            src_pick = cw[idx[3:0]];
         end
      end
   endfunction

   // Limit a signed value to a window
   function signed [15:0] clamp;
      input signed [15:0] v;
      input signed [15:0] lo;
      input signed [15:0] hi;
      begin
         if (v < lo)
            clamp = lo;
         else if (v > hi)
            clamp = hi;
         else
            clamp = v;
      end
   endfunction

   reg [1:0] rst_sync;
   wire rst_n;
   reg [15:0] di_meta;
   reg [15:0] di_sync;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [31:0] tmr_cyc_reg;
   reg [11:0] tmr_sec_reg;
   reg [31:0] cs_cyc_reg;
   reg cs_tick_reg;
   reg sleep_cond;
   reg signed [15:0] speed_next;
   wire pid_mode;
   wire sw_active;
   wire cond_speed;
   wire cond_power;
   wire wake_fb;
   wire wake_er;
   wire wake_ok;
   wire sleep_arm;
   wire sec_tick;
   wire tmr_clear;
   wire delay_done;
   wire boost_done;
   wire [16:0] err_mag;
   wire signed [17:0] fb_s;
   wire signed [17:0] wake_lo;
   wire signed [17:0] wake_hi;
   wire [15:0] ramp_target;
   wire [13:0] ramp_time;
   wire [15:0] ramp_level;
   wire ramp_done;

   // Reset release through two flops
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // Digital input pins synchronised before use
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         di_meta <= 16'h0000;
         di_sync <= 16'h0000;
      end else begin
         di_meta <= di_pins;
         di_sync <= di_meta;
      end
   end

   // PID control mode qualification
   assign pid_mode = pid_configured & chan1_sel & pid_auto;

   // Error magnitude against warning level
   assign err_mag = pid_error[15] ? (17'h00000 - {pid_error[15], pid_error}) : {1'b0, pid_error};

   // Individual sleep conditions
   assign sw_active = src_pick(sleep_sw_sel, di_sync, ctrl_word);
   assign cond_speed = (out_freq < sleep_speed);
   assign cond_power = (out_power < sleep_on_power);

   // Selected sleep detection mode
   always @* begin
      case (sleep_mode)
         `SLP_SWITCH: sleep_cond = sw_active;
         `SLP_SPEED: sleep_cond = cond_speed;
         `SLP_POWER: sleep_cond = cond_power;
         `SLP_MULTI: sleep_cond = sw_active | cond_speed | cond_power;
         default: sleep_cond = 1'b0;
      endcase
   end

   // Wake-up thresholds, direct or reverse action
   assign fb_s = $signed({2'b00, feedback});
   assign wake_lo = $signed({2'b00, pid_ref}) - $signed({2'b00, wake_err});
   assign wake_hi = $signed({2'b00, pid_ref}) + $signed({2'b00, wake_err});
   assign wake_fb = pid_inversion ? (feedback > wake_level) : (feedback < wake_level);
   assign wake_er = pid_inversion ? (fb_s > wake_hi) : (fb_s < wake_lo);
   assign wake_ok = (wake_mode == `WAKE_ERROR) ? wake_er : wake_fb;

   // Sleep only qualifies without a wake condition
   assign sleep_arm = sleep_cond & ~wake_ok;

   // State timer, cleared on state change or lost condition
   assign sec_tick = (tmr_cyc_reg == SEC_CYCLES - 1);
   assign tmr_clear = (state_next != state_reg) || (state_reg == `ST_PID && !sleep_arm);
   assign delay_done = sec_tick && (tmr_sec_reg >= sleep_delay_s);
   assign boost_done = sec_tick && ((tmr_sec_reg + 12'h001) >= boost_time_s);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_cyc_reg <= 32'h00000000;
         tmr_sec_reg <= 12'h000;
      end else if (tmr_clear) begin
         tmr_cyc_reg <= 32'h00000000;
         tmr_sec_reg <= 12'h000;
      end else if (sec_tick) begin
         tmr_cyc_reg <= 32'h00000000;
         if (tmr_sec_reg != 12'hFFF)
            tmr_sec_reg <= tmr_sec_reg + 12'h001;
      end else begin
         tmr_cyc_reg <= tmr_cyc_reg + 32'h00000001;
      end
   end

   // Free running ramp tick, one per hundredth of a second
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_cyc_reg <= 32'h00000000;
         cs_tick_reg <= 1'b0;
      end else if (cs_cyc_reg == CS_CYCLES - 1) begin
         cs_cyc_reg <= 32'h00000000;
         cs_tick_reg <= 1'b1;
      end else begin
         cs_cyc_reg <= cs_cyc_reg + 32'h00000001;
         cs_tick_reg <= 1'b0;
      end
   end

   // Start ramp target and time
   assign ramp_target = (start_ref_freq < low_speed) ? low_speed : start_ref_freq;
   assign ramp_time = start_accel_en ? start_accel_cs : accel_time_cs;

   start_ramp u_ramp (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(state_reg != `ST_START),
      .tick(cs_tick_reg),
      .full_scale(max_out[15] ? 16'h0000 : max_out),
      .time_cs(ramp_time),
      .target(ramp_target),
      .level_reg(ramp_level),
      .done(ramp_done)
   );

   // Supervisor state transitions
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ST_STOP: begin
            if (run_cmd) begin
               if (!pid_mode)
                  state_next = `ST_MAN;
               else if (wake_ok)
                  state_next = `ST_START;
               else
                  state_next = `ST_SLEEP;
            end
         end
         `ST_MAN: begin
            if (pid_mode)
               state_next = `ST_PID;
         end
         `ST_START: begin
            if (!pid_mode)
               state_next = `ST_MAN;
            else if (ramp_done)
               state_next = `ST_PID;
         end
         `ST_PID: begin
            if (!pid_mode)
               state_next = `ST_MAN;
            else if (sleep_arm && delay_done) begin
               if (boost_time_s == 12'h000)
                  state_next = `ST_SLEEP;
               else
                  state_next = `ST_BOOST;
            end
         end
         `ST_BOOST: begin
            if (!pid_mode)
               state_next = `ST_MAN;
            else if (boost_done)
               state_next = `ST_SLEEP;
         end
         `ST_SLEEP: begin
            if (!pid_mode)
               state_next = `ST_MAN;
            else if (wake_ok)
               state_next = `ST_START;
         end
         default: state_next = `ST_STOP;
      endcase
      if (!run_cmd)
         state_next = `ST_STOP;
   end

   // Speed command for each state
   always @* begin
      case (state_next)
         `ST_MAN: speed_next = manual_freq;
         `ST_START: speed_next = ramp_level;
         `ST_PID: speed_next = clamp(pid_out, min_out, max_out);
         `ST_BOOST: speed_next = boost_speed;
         default: speed_next = `SPEED_RST;
      endcase
   end

   // Registered state and outputs
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= `ST_STOP;
         speed_cmd_reg <= `SPEED_RST;
         motor_run_reg <= 1'b0;
         pid_run_reg <= 1'b0;
         int_hold_reg <= 1'b0;
         err_warn_reg <= 1'b0;
         sleep_reg <= 1'b0;
         boost_reg <= 1'b0;
         pid_mode_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         speed_cmd_reg <= speed_next;
         motor_run_reg <= (state_next != `ST_STOP) && (state_next != `ST_SLEEP);
         pid_run_reg <= (state_next == `ST_PID);
         int_hold_reg <= src_pick(int_off_sel, di_sync, ctrl_word);
         err_warn_reg <= (err_mag > {1'b0, pid_error_warning_level});
         sleep_reg <= (state_next == `ST_SLEEP);
         boost_reg <= (state_next == `ST_BOOST);
         pid_mode_reg <= pid_mode;
      end
   end

endmodule // pid_sleep_wake_supervisor

// >>> tb/supervisor_properties.sv
`timescale 1ns/1ps
// Watches the supervisor outputs against their causes
module supervisor_properties (
   input logic sys_clk, nrst, run_cmd, pid_configured, chan1_sel, pid_auto,
   input logic [15:0] ctrl_word, pid_error_warning_level, boost_speed,
   input logic [5:0] int_off_sel,
   input logic signed [15:0] pid_out, pid_error, min_out, max_out, speed_cmd_reg,
   input logic motor_run_reg, pid_run_reg, int_hold_reg, err_warn_reg, sleep_reg, boost_reg, pid_mode_reg
);
   // Outputs are meaningful from the fourth edge after release
   logic [3:0] live_reg;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) live_reg <= 4'h0;
      else live_reg <= {live_reg[2:0], 1'b1};
   // Error magnitude, clamp result and selected control bit
   wire [15:0] mag = pid_error[15] ? 16'h0000 - pid_error : pid_error;
   wire signed [15:0] clp = pid_out < min_out ? min_out : (pid_out > max_out ? max_out : pid_out);
   wire cw_sel = int_off_sel > 6'h10 && int_off_sel < 6'h21;
   wire cw_bit = ctrl_word[int_off_sel[3:0] - 4'h1];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!live_reg[3]);
   a_warn_level: assert property (err_warn_reg == ($past(mag) > $past(pid_error_warning_level)))
      else $error("warning flag wrong");
   a_pid_mode: assert property (pid_mode_reg == $past(pid_configured & chan1_sel & pid_auto))
      else $error("pid mode flag wrong");
   a_integral_bit: assert property (cw_sel |=> int_hold_reg == $past(cw_bit))
      else $error("integral hold wrong");
   a_output_clamp: assert property (pid_run_reg |-> speed_cmd_reg == $past(clp))
      else $error("pid output not clamped");
   a_sleep_quiet: assert property (sleep_reg |-> !motor_run_reg && !pid_run_reg && speed_cmd_reg == 16'sh0000)
      else $error("motor active in sleep");
   a_boost_speed: assert property (boost_reg |-> motor_run_reg && !sleep_reg && speed_cmd_reg == $past(boost_speed))
      else $error("boost speed wrong");
   a_run_order: assert property (!$past(run_cmd) |-> !motor_run_reg && !sleep_reg)
      else $error("running without run order");
   a_stop_idle: assert property (!motor_run_reg |-> speed_cmd_reg == 16'sh0000)
      else $error("speed while stopped");
   c_boost: cover property ($rose(boost_reg));
   c_sleep: cover property ($rose(sleep_reg));
   c_pid: cover property ($rose(pid_run_reg));
endmodule // supervisor_properties
bind pid_sleep_wake_supervisor supervisor_properties supervisor_properties_inst (
   .sys_clk(sys_clk), .nrst(nrst), .run_cmd(run_cmd), .pid_configured(pid_configured), .chan1_sel(chan1_sel),
   .pid_auto(pid_auto), .ctrl_word(ctrl_word), .pid_error_warning_level(pid_error_warning_level),
   .boost_speed(boost_speed), .int_off_sel(int_off_sel), .pid_out(pid_out), .pid_error(pid_error),
   .min_out(min_out), .max_out(max_out), .speed_cmd_reg(speed_cmd_reg), .motor_run_reg(motor_run_reg),
   .pid_run_reg(pid_run_reg), .int_hold_reg(int_hold_reg), .err_warn_reg(err_warn_reg), .sleep_reg(sleep_reg),
   .boost_reg(boost_reg), .pid_mode_reg(pid_mode_reg));

// >>> tb/motor_plant.sv
`timescale 1ns/1ps
// Motor and sensor behind the speed command
module motor_plant (
   input wire sys_clk,
   input wire signed [15:0] speed_cmd,
   input wire motor_run,
   input wire [15:0] fb_target,
   output logic [15:0] out_freq,
   output logic [15:0] out_power,
   output logic [15:0] feedback
);
   // Frequency follows a cycle late, power scales with it
   always @(posedge sys_clk) begin
      out_freq <= motor_run ? speed_cmd : 16'h0000;
      out_power <= out_freq >> 1;
      feedback <= fb_target;
   end
endmodule // motor_plant

// >>> tb/tb_pid_sleep_wake_supervisor.sv
`timescale 1ns/1ps
module tb_pid_sleep_wake_supervisor;
   logic sys_clk, nrst, run_cmd, pid_auto, pid_inversion, start_accel_en, wake_mode, pid_configured, chan1_sel;
   logic [15:0] di_pins, ctrl_word, pid_error_warning_level, low_speed, manual_freq, sleep_speed;
   logic [15:0] sleep_on_power, boost_speed, wake_level, wake_err, pid_ref, fb_target;
   logic signed [15:0] pid_out, pid_error, min_out, max_out;
   logic [5:0] int_off_sel, sleep_sw_sel;
   logic [2:0] sleep_mode;
   logic [11:0] sleep_delay_s, boost_time_s;
   wire [15:0] out_freq, out_power, feedback;
   wire signed [15:0] speed_cmd_reg;
   wire motor_run_reg, pid_run_reg, int_hold_reg, err_warn_reg, sleep_reg, boost_reg, pid_mode_reg;
   wire [3:0] flags = {pid_run_reg, motor_run_reg, sleep_reg, boost_reg};
   int err_total, checks, k, boosts;
   logic signed [15:0] ev [4] = '{16'sh0064, 16'sh0065, -16'sh0064, -16'sh0065};
   logic [15:0] bad [4] = '{16'h03E8, 16'h03E8, 16'h0384, 16'h044C};
   logic [15:0] good [4] = '{16'h03E7, 16'h03E9, 16'h0383, 16'h044D};
   logic [2:0] smode [4] = '{3'h2, 3'h3, 3'h4, 3'h4};
   pid_sleep_wake_supervisor #(.SEC_CYCLES(20), .CS_CYCLES(4)) pid_sleep_wake_supervisor_inst (
      .sys_clk(sys_clk), .nrst(nrst), .di_pins(di_pins), .ctrl_word(ctrl_word), .run_cmd(run_cmd),
      .pid_configured(pid_configured), .chan1_sel(chan1_sel), .pid_auto(pid_auto), .pid_inversion(pid_inversion),
      .pid_out(pid_out), .pid_error(pid_error), .pid_error_warning_level(pid_error_warning_level),
      .int_off_sel(int_off_sel), .min_out(min_out), .max_out(max_out), .accel_time_cs(14'h0003),
      .start_accel_en(start_accel_en), .start_accel_cs(14'h0002), .low_speed(low_speed),
      .start_ref_freq(16'h0000), .manual_freq(manual_freq), .sleep_mode(sleep_mode), .sleep_sw_sel(sleep_sw_sel),
      .sleep_speed(sleep_speed), .sleep_on_power(sleep_on_power), .out_freq(out_freq), .out_power(out_power),
      .sleep_delay_s(sleep_delay_s), .boost_speed(boost_speed), .boost_time_s(boost_time_s), .wake_mode(wake_mode),
      .wake_level(wake_level), .wake_err(wake_err), .pid_ref(pid_ref), .feedback(feedback),
      .speed_cmd_reg(speed_cmd_reg), .motor_run_reg(motor_run_reg), .pid_run_reg(pid_run_reg),
      .int_hold_reg(int_hold_reg), .err_warn_reg(err_warn_reg), .sleep_reg(sleep_reg), .boost_reg(boost_reg),
      .pid_mode_reg(pid_mode_reg));
   motor_plant motor_plant_inst (.sys_clk(sys_clk), .speed_cmd(speed_cmd_reg), .motor_run(motor_run_reg),
      .fb_target(fb_target), .out_freq(out_freq), .out_power(out_power), .feedback(feedback));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Counts boost cycles while boost time is zero
   always @(posedge sys_clk) if (boost_reg && boost_time_s == 12'h000) boosts++;
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for one state flag
   task automatic wait_flag(input int b, input logic lvl, input int lim, input string what);
      k = 0;
      while (flags[b] !== lvl && k < lim) begin
         step(1);
         k++;
      end
      chk(what, lvl, flags[b]);
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      {nrst, run_cmd, pid_inversion, start_accel_en, wake_mode, di_pins, ctrl_word, pid_error, int_off_sel,
         sleep_mode, sleep_sw_sel, sleep_speed, sleep_on_power, sleep_delay_s, boost_time_s} = '0;
      {pid_auto, pid_configured, chan1_sel, pid_error_warning_level, min_out, max_out} =
         {3'b111, 16'h0064, 16'h0014, 16'h0258};
      {low_speed, manual_freq, pid_out, boost_speed} = {16'h0010, 16'h0055, 16'h0100, 16'h0123};
      {wake_level, pid_ref, wake_err, fb_target} = {16'h03E8, 16'h03E8, 16'h0064, 16'h03E8};
      step(12);
      nrst = 1'b1;
      step(4);
      // Warning flag around its level
      foreach (ev[i]) begin
         pid_error = ev[i];
         step(1);
         chk("err_warn", ev[i] > 100 || ev[i] < -100, err_warn_reg);
      end
      // Integral inhibit: none, control bit 3, input pin 5
      ctrl_word = 16'hFFFF;
      step(1);
      chk("int_hold none", 0, int_hold_reg);
      int_off_sel = 6'h14;
      step(1);
      chk("int_hold bit", 1, int_hold_reg);
      ctrl_word = 16'hFFF7;
      step(1);
      chk("int_hold bit", 0, int_hold_reg);
      {int_off_sel, di_pins, ctrl_word} = {6'h05, 16'h0010, 16'h0000};
      step(3);
      chk("int_hold pin", 1, int_hold_reg);
      pid_auto = 1'b0;
      step(1);
      chk("pid_mode", 0, pid_mode_reg);
      {pid_auto, pid_configured} = 2'b10;
      step(1);
      chk("pid_mode cfg", 0, pid_mode_reg);
      {pid_configured, chan1_sel} = 2'b10;
      step(1);
      chk("pid_mode chan", 0, pid_mode_reg);
      chan1_sel = 1'b1;
      step(1);
      chk("pid_mode on", 1, pid_mode_reg);
      step(1);
      // Run order without wake, then wake and ramp
      run_cmd = 1'b1;
      step(1);
      chk("sleep at run", 1, sleep_reg);
      fb_target = 16'h03E7;
      wait_flag(2, 1, 4, "wake");
      wait_flag(3, 1, 3000, "ramp end");
      chk("speed", 16'h0100, speed_cmd_reg);
      pid_out = 16'h0300;
      step(1);
      chk("clamp high", 16'h0258, speed_cmd_reg);
      pid_out = -16'sh0005;
      step(1);
      chk("clamp low", 16'h0014, speed_cmd_reg);
      // Switch sleep with one dropout, delay setting 1 (two timer seconds, 40 cycles) and boost
      {fb_target, pid_out, sleep_mode, sleep_sw_sel} = {16'h03E8, 16'h0100, 3'h1, 6'h12};
      {sleep_delay_s, boost_time_s} = {12'h001, 12'h001};
      ctrl_word = 16'h0002;
      step(30);
      ctrl_word = 16'h0000;
      step(1);
      ctrl_word = 16'h0002;
      step(38);
      chk("boost early", 0, boost_reg);
      wait_flag(0, 1, 4, "boost entry");
      chk("boost speed", 16'h0123, speed_cmd_reg);
      step(17);
      chk("boost hold", 1, boost_reg);
      wait_flag(1, 1, 5, "sleep after boost");
      // Each wake kind at its boundary, speed, power and multi sleep modes, no boost
      {sleep_delay_s, boost_time_s, ctrl_word, sleep_sw_sel} = {12'h000, 12'h000, 16'h0000, 6'h01};
      for (int i = 0; i < 4; i++) begin
         {wake_mode, pid_inversion, start_accel_en, fb_target} = {i[1], i[0], i[0], bad[i]};
         step(3);
         chk("asleep at limit", 1, sleep_reg);
         fb_target = good[i];
         wait_flag(2, 1, 4, "wake");
         wait_flag(3, 1, 3000, "ramp end");
         {fb_target, sleep_mode} = {bad[i], smode[i]};
         sleep_speed = (i == 0) ? 16'h0200 : 16'h0000;
         sleep_on_power = i[0] ? 16'h0200 : 16'h0000;
         di_pins = (i == 2) ? 16'h0001 : 16'h0000;
         wait_flag(1, 1, 30, "sleep entry");
         {sleep_speed, sleep_on_power, di_pins} = '0;
      end
      // Manual and back to automatic while running
      fb_target = good[3];
      wait_flag(3, 1, 3000, "ramp end");
      pid_auto = 1'b0;
      step(1);
      chk("manual speed", 16'h0055, speed_cmd_reg);
      pid_auto = 1'b1;
      step(1);
      chk("auto direct", 1, pid_run_reg);
      run_cmd = 1'b0;
      step(1);
      chk("stopped", 0, motor_run_reg);
      chk("boost skipped", 0, boosts[15:0]);
      tally_and_finish;
   end
endmodule // tb_pid_sleep_wake_supervisor
